// >>> logic/irq_coproc_unit.sv
// Input-side event logic: coprocessor handshake, interrupts, reset
// Behaviour
// RQ1: Operand request moves operand using stored opcode
// RQ2: Operand request is async active-high level
// RQ3: Stack/wait instructions wait for not-ready high
// RQ4: No-wait coprocessor instructions ignore not-ready
// RQ5: Not-ready low at reset release selects self-test
// RQ6: Fault low on coprocessor instruction raises 16
// RQ7: Listed store/clear instructions never raise 16
// RQ8: Not-ready and fault are async active-low levels
// RQ9: Maskable irq gives two acks, captures byte
// RQ10: Maskable irq held eight periods before boundary
// RQ11: Source holds irq until first ack
// RQ12: NMI uses entry 2, no ack, unmaskable
// RQ13: NMI low eight then high eight
// RQ14: NMI blocked until return, one edge latched
// RQ15: Interrupts only at boundaries or string iterations
// RQ16: Stack segment load defers one instruction
// RQ17: Flag set defers one instruction
// RQ18: Reset held 15, or 80 for self-test
// RQ19: Reset forces idle pin levels
// RQ20: Reset beats bus takeover request
// RQ21: Reset is synchronous active-high level
// RQ22: NMI edge during takeover latched for later
// RQ23: Async inputs pass two-stage synchroniser
// Assumes the execution unit drives boundary and class strobes on core_clk_i
`timescale 1ns/100ps
`include "irq_coproc_defs.svh"
module irq_coproc_unit
  import irq_coproc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Asynchronous pins
  input wire logic coproc_operand_req_i,
  input wire logic coproc_not_ready_n_i,
  input wire logic numeric_fault_n_i,
  input wire logic maskable_irq_i,
  input wire logic nonmaskable_irq_i,
  // Bus takeover
  input wire logic bus_takeover_req_i,
  // Execution unit strobes
  input wire logic instr_boundary_i,
  input wire logic string_iter_i,
  input wire cp_class_t cp_class_i,
  input wire logic cp_fault_exempt_i,
  input wire logic cp_dir_write_i,
  input wire logic [22:0] cp_addr_i,
  input wire logic irq_mask_flag_i,
  input wire logic stack_seg_load_i,
  input wire logic irq_enable_instr_i,
  input wire logic irq_return_instr_i,
  // Bus cycle feedback
  input wire logic bus_cycle_done_i,
  input wire logic [15:0] data_in_i,
  // Bus pins
  output logic addr_strobe_n_o,
  output logic [22:0] addr_o,
  output logic upper_byte_sel_n_o,
  output logic lower_byte_sel_n_o,
  output logic write_not_read_o,
  output logic data_not_code_o,
  output logic mem_not_io_o,
  output logic bus_lock_n_o,
  output logic data_oe_o,
  output logic bus_takeover_grant_o,
  // Events to the execution unit
  output logic cp_proceed_o,
  output logic exc_valid_o,
  output logic [7:0] exc_vector_o,
  output logic selftest_o,
  output logic operand_xfer_o,
  output logic operand_write_o
);
  // ==========================================================
  // Synchronisers
  logic req_s, busy_n_s, fault_n_s, maskable_irq_s, nmi_s;
  sync2 #(.RESET_VAL(1'b0)) u_s_req (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .async_i(coproc_operand_req_i), .sync_o(req_s)); // RQ23 RQ2
  sync2 #(.RESET_VAL(1'b1)) u_s_busy (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .async_i(coproc_not_ready_n_i), .sync_o(busy_n_s)); // RQ23 RQ8
  sync2 #(.RESET_VAL(1'b1)) u_s_fault (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .async_i(numeric_fault_n_i), .sync_o(fault_n_s)); // RQ23 RQ8
  sync2 #(.RESET_VAL(1'b0)) u_s_maskable_irq (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .async_i(maskable_irq_i), .sync_o(maskable_irq_s)); // RQ23
  sync2 #(.RESET_VAL(1'b0)) u_s_nmi (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .async_i(nonmaskable_irq_i), .sync_o(nmi_s)); // RQ23

  // ==========================================================
  // Hold qualifiers
  logic maskable_irq_held, nmi_low_held, nmi_high_held;
  hold_counter #(.MAX(int'(`IRQ_HOLD_CYCLES))) u_h_maskable_irq (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .level_i(maskable_irq_s), .held_o(maskable_irq_held)); // RQ10
  hold_counter #(.MAX(int'(`IRQ_HOLD_CYCLES))) u_h_nlo (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .level_i(!nmi_s), .held_o(nmi_low_held)); // RQ13
  hold_counter #(.MAX(int'(`IRQ_HOLD_CYCLES))) u_h_nhi (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .level_i(nmi_s), .held_o(nmi_high_held)); // RQ13

  // ==========================================================
  // Reset length and self-test strap
  logic [6:0] rst_cnt;
  logic rst_d, rst_dd;
  always_ff @(posedge core_clk_i) begin
    rst_d <= rst_i; // RQ21
    rst_dd <= rst_d;
    if (rst_i) begin
      if (rst_cnt != 7'h7F) begin
        rst_cnt <= rst_cnt + 7'h01;
      end
    end else if (!rst_d) begin
      rst_cnt <= 7'h00;
    end
  end
  // Judged one cycle late so the strap has passed both flops
  wire rst_fall = rst_dd && !rst_d;
  // Own flop pair; the shared synchroniser is held in reset then
  logic busy_pin_meta, busy_pin_q;
  always_ff @(posedge core_clk_i) begin
    busy_pin_meta <= coproc_not_ready_n_i;
    busy_pin_q <= busy_pin_meta;
  end
  // Self-test only honoured after the long reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      selftest_o <= 1'b0;
    end else if (rst_fall) begin
      selftest_o <= !busy_pin_q && (rst_cnt >= `RESET_SELFTEST_CYCLES); // RQ5 RQ18
    end else begin
      selftest_o <= 1'b0;
    end
  end

  // ==========================================================
  // NMI edge capture and blocking
  logic nmi_armed, nmi_pending, nmi_active;
  wire nmi_edge = nmi_armed && nmi_high_held;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nmi_armed <= 1'b0;
    end else if (nmi_low_held) begin
      nmi_armed <= 1'b1;
    end else if (nmi_high_held) begin
      nmi_armed <= 1'b0;
    end
  end

  // ==========================================================
  // Deferral after stack segment load or flag set
  logic defer;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      defer <= 1'b0;
    end else if (stack_seg_load_i || irq_enable_instr_i) begin
      defer <= 1'b1; // RQ16 RQ17
    end else if (instr_boundary_i) begin
      defer <= 1'b0;
    end
  end

  // ==========================================================
  // Takeover grant, reset wins
  logic grant;
  seq_state_t state, next_state;
  // Granted only between bus cycles, never mid-cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      grant <= 1'b0; // RQ20
    end else begin
      grant <= bus_takeover_req_i && (grant || next_state == ST_IDLE);
    end
  end

  // ==========================================================
  // Acceptance points
  wire accept_pt = (instr_boundary_i || string_iter_i) && !defer; // RQ15
  wire idle_ok = (state == ST_IDLE) && !grant && !rst_i;
  wire take_nmi = idle_ok && accept_pt && nmi_pending && !nmi_active; // RQ12 RQ14 RQ22
  wire take_maskable_irq = idle_ok && accept_pt && !take_nmi && irq_mask_flag_i && maskable_irq_held; // RQ9 RQ10
  wire cp_stack = (cp_class_i == CP_STACK);
  wire cp_any = (cp_class_i != CP_NONE);
  wire take_fault = idle_ok && cp_any && !fault_n_s && !cp_fault_exempt_i; // RQ6 RQ7
  wire take_oper = idle_ok && req_s && !take_nmi && !take_maskable_irq && !take_fault; // RQ1

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nmi_pending <= 1'b0;
      nmi_active <= 1'b0;
    end else begin
      // Set wins over clear, so a second edge is latched
      if (nmi_edge) begin
        nmi_pending <= 1'b1; // RQ14 RQ22
      end else if (take_nmi) begin
        nmi_pending <= 1'b0;
      end
      if (take_nmi) begin
        nmi_active <= 1'b1;
      end else if (irq_return_instr_i) begin
        nmi_active <= 1'b0; // RQ14
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_nmi) begin
          next_state = ST_NMI;
        end else if (take_maskable_irq) begin
          next_state = ST_ACK1;
        end else if (take_fault) begin
          next_state = ST_FAULT;
        end else if (take_oper) begin
          next_state = ST_OPERAND;
        end
      end
      ST_ACK1: begin
        if (bus_cycle_done_i) begin
          next_state = ST_ACK2;
        end
      end
      ST_ACK2: begin
        if (bus_cycle_done_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_OPERAND: begin
        if (bus_cycle_done_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_NMI: next_state = ST_IDLE;
      ST_FAULT: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Event outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      exc_valid_o <= 1'b0;
      exc_vector_o <= 8'h00;
      cp_proceed_o <= 1'b0;
      operand_xfer_o <= 1'b0;
      operand_write_o <= 1'b0;
    end else begin
      exc_valid_o <= 1'b0;
      if (state == ST_ACK2 && bus_cycle_done_i) begin
        exc_valid_o <= 1'b1;
        exc_vector_o <= data_in_i[7:0]; // RQ9
      end else if (state == ST_NMI) begin
        exc_valid_o <= 1'b1;
        exc_vector_o <= `NMI_TABLE_ENTRY; // RQ12
      end else if (state == ST_FAULT) begin
        exc_valid_o <= 1'b1;
        exc_vector_o <= `FAULT_EXC_NUM; // RQ6
      end
      // Stack ops wait on not-ready; no-wait class goes at once
      cp_proceed_o <= (cp_stack && busy_n_s) || (cp_class_i == CP_NOWAIT); // RQ3 RQ4
      operand_xfer_o <= take_oper; // RQ1
      if (take_oper) begin
        operand_write_o <= cp_dir_write_i; // RQ1
      end
    end
  end

  // ==========================================================
  // Bus pins; acknowledge cycles are locked, address unused
  wire in_ack = (next_state == ST_ACK1) || (next_state == ST_ACK2);
  wire in_oper = (next_state == ST_OPERAND);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_strobe_n_o <= 1'b1; // RQ19
      addr_o <= `IDLE_ADDR;
      upper_byte_sel_n_o <= 1'b0;
      lower_byte_sel_n_o <= 1'b0;
      write_not_read_o <= 1'b0;
      data_not_code_o <= 1'b1;
      mem_not_io_o <= 1'b0;
      bus_lock_n_o <= 1'b1;
      data_oe_o <= 1'b0;
      bus_takeover_grant_o <= 1'b0; // RQ20
    end else begin
      addr_strobe_n_o <= !((state == ST_IDLE && (in_ack || in_oper))
        || (state == ST_ACK1 && bus_cycle_done_i));
      addr_o <= in_oper ? cp_addr_i : `IDLE_ADDR;
      upper_byte_sel_n_o <= 1'b1;
      lower_byte_sel_n_o <= !(in_ack || in_oper);
      write_not_read_o <= in_oper && cp_dir_write_i;
      data_not_code_o <= !in_ack;
      mem_not_io_o <= in_oper;
      bus_lock_n_o <= !in_ack;
      data_oe_o <= in_oper && cp_dir_write_i;
      bus_takeover_grant_o <= grant;
    end
  end
endmodule

// >>> logic/irq_coproc_defs.svh
// Timing counts and fixed numbers for the input-side event logic
// Assumes inclusion by bare name from the irq_coproc_unit module
`ifndef IRQ_COPROC_DEFS_SVH
`define IRQ_COPROC_DEFS_SVH
// Exception and interrupt table entries
`define FAULT_EXC_NUM 8'h10
`define NMI_TABLE_ENTRY 8'h02
// Minimum request hold, in clock periods
`define IRQ_HOLD_CYCLES 4'h8
// Minimum reset lengths, in clock periods
`define RESET_MIN_CYCLES 7'h0F
`define RESET_SELFTEST_CYCLES 7'h50
// Idle pin levels during reset
`define IDLE_ADDR 23'h7FFFFF
`endif

// >>> logic/irq_coproc_pkg.sv
// Types shared by the input-side event logic
// Assumes the defs header is on the include path
package irq_coproc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACK1,
    ST_ACK2,
    ST_NMI,
    ST_FAULT,
    ST_OPERAND
  } seq_state_t;
  // Instruction classes seen by the coprocessor gate
  typedef enum logic [1:0] {
    CP_NONE,
    CP_STACK,
    CP_NOWAIT
  } cp_class_t;
endpackage

// >>> logic/sync2.sv
// Two-flop synchroniser for one asynchronous level
// Assumes a single clock and a synchronous reset
`timescale 1ns/100ps
module sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);
  logic meta;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// >>> logic/hold_counter.sv
// Counts consecutive cycles a level has held, saturating at MAX
// Assumes the level is already synchronised
`timescale 1ns/100ps
module hold_counter #(
  parameter int MAX = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Level and result
  input wire logic level_i,
  output logic held_o
);
  localparam int W = $clog2(MAX + 1);
  logic [W-1:0] cnt;
  // Refused at elaboration; a zero count would report held at once, even with the level low
  if (MAX < 1) begin : g_bad_max
    $error("hold_counter MAX must be at least 1");
  end
  assign held_o = (cnt == W'(MAX));
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !level_i) begin
      cnt <= '0;
    end else if (!held_o) begin
      cnt <= cnt + W'(1);
    end
  end
endmodule

// >>> dv/irq_coproc_unit_sva.sv
// Concurrent checks on the input-side event logic ports
// Assumes binding onto irq_coproc_unit, one clock, sync reset
`timescale 1ns/100ps
module irq_coproc_unit_sva
  import irq_coproc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Inputs watched
  input wire logic coproc_not_ready_n_i,
  input wire logic bus_takeover_req_i,
  input wire cp_class_t cp_class_i,
  input wire logic cp_dir_write_i,
  input wire logic irq_mask_flag_i,
  // Outputs watched
  input wire logic addr_strobe_n_o,
  input wire logic [22:0] addr_o,
  input wire logic upper_byte_sel_n_o,
  input wire logic lower_byte_sel_n_o,
  input wire logic write_not_read_o,
  input wire logic data_not_code_o,
  input wire logic mem_not_io_o,
  input wire logic bus_lock_n_o,
  input wire logic data_oe_o,
  input wire logic bus_takeover_grant_o,
  input wire logic cp_proceed_o,
  input wire logic exc_valid_o,
  input wire logic selftest_o,
  input wire logic operand_xfer_o,
  input wire logic operand_write_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Reset length and strap, saturating so long resets never wrap
  logic [6:0] run = 7'h00;
  logic [6:0] len = 7'h00;
  logic strap = 1'b1;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run <= run + {6'h00, run != 7'h7E};
      len <= run + 7'h01;
      strap <= coproc_not_ready_n_i;
    end else begin
      run <= 7'h00;
    end
  end
  // ==========
  // Properties
  a_reset_idle: assert property (
    $fell(rst_i) |-> addr_strobe_n_o && &addr_o && !upper_byte_sel_n_o && !lower_byte_sel_n_o
      && !write_not_read_o && data_not_code_o && !mem_not_io_o && bus_lock_n_o && !data_oe_o)
    else $error("pins not idle out of reset");
  a_reset_grant: assert property (
    $fell(rst_i) && $past(bus_takeover_req_i) |-> !bus_takeover_grant_o)
    else $error("grant survived reset");
  a_grant_quiet: assert property (
    bus_takeover_grant_o |-> addr_strobe_n_o && !data_oe_o)
    else $error("bus cycle during takeover");
  a_selftest_gate: assert property (
    selftest_o |-> len >= 7'h50 && !strap)
    else $error("self-test without low strap and long reset");
  a_ack_kind: assert property (
    !addr_strobe_n_o && !data_not_code_o |-> !mem_not_io_o && !write_not_read_o && !bus_lock_n_o)
    else $error("acknowledge cycle badly encoded");
  a_ack_masked: assert property (
    !addr_strobe_n_o && !data_not_code_o && $past(bus_lock_n_o) |-> $past(irq_mask_flag_i))
    else $error("acknowledge while masked");
  a_stack_wait: assert property (
    (cp_class_i == CP_STACK && !coproc_not_ready_n_i) [*4] |-> !cp_proceed_o)
    else $error("proceed while coprocessor busy");
  a_nowait_go: assert property (
    (cp_class_i == CP_NOWAIT) [*2] |-> cp_proceed_o)
    else $error("no-wait instruction held");
  a_operand_dir: assert property (
    operand_xfer_o |-> operand_write_o == $past(cp_dir_write_i))
    else $error("operand direction wrong");
endmodule

bind irq_coproc_unit irq_coproc_unit_sva i_sva (.*);

// >>> dv/ack_responder.sv
// Far-side responder: ends each bus cycle, returns a vector byte
// Assumes the bench gives a wait of 1 to 3 and the vector
`timescale 1ns/100ps
module ack_responder (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus side
  input wire logic addr_strobe_n_i,
  output logic bus_cycle_done_o,
  output logic [15:0] data_o,
  // Control
  input wire logic [1:0] wait_i,
  input wire logic [7:0] vec_i
);
  logic busy = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial bus_cycle_done_o = 1'b0;
  initial data_o = 16'h0000;
  always @(posedge core_clk_i) begin
    #1;
    bus_cycle_done_o = 1'b0;
    // Idle data toggles so a stale byte never looks valid
    data_o = ~data_o;
    if (rst_i)
      busy = 1'b0;
    else if (busy)
      cnt = cnt + 2'h1;
    else if (!addr_strobe_n_i) begin
      busy = 1'b1;
      cnt = 2'h0;
    end
    if (busy && cnt == wait_i) begin
      busy = 1'b0;
      bus_cycle_done_o = 1'b1;
      data_o = {~vec_i, vec_i};
    end
  end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the input-side event logic
// Assumes the checker binds itself and the responder ends cycles
`timescale 1ns/100ps
module tb;
  import irq_coproc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic opreq = 1'b0, nrdy_n = 1'b1, flt_n = 1'b1, mirq = 1'b0, nmi = 1'b0, treq = 1'b0;
  logic bnd = 1'b0, siter = 1'b0, exempt = 1'b0, dir = 1'b0, mask = 1'b0;
  logic ssl = 1'b0, ien = 1'b0, irq_return_instr = 1'b0, done;
  cp_class_t cls = CP_NONE;
  logic [22:0] caddr = 23'h000000;
  logic [1:0] wt = 2'h1;
  logic [7:0] vec = 8'h00;
  logic [15:0] din;
  logic ads_n, ube_n, lbe_n, wnr, dnc, mnio, lock_n, doe, grant, go, exv, stest, oxfer, owr;
  logic [22:0] addr;
  logic [7:0] exvec;
  logic [8:0] r;
  int failures = 0;
  int n_compared = 0;
  int seed = 48;
  int i;
  always #5 core_clk_i = ~core_clk_i;
  irq_coproc_unit i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .coproc_operand_req_i(opreq),
    .coproc_not_ready_n_i(nrdy_n), .numeric_fault_n_i(flt_n), .maskable_irq_i(mirq),
    .nonmaskable_irq_i(nmi), .bus_takeover_req_i(treq), .instr_boundary_i(bnd),
    .string_iter_i(siter), .cp_class_i(cls), .cp_fault_exempt_i(exempt), .cp_dir_write_i(dir),
    .cp_addr_i(caddr), .irq_mask_flag_i(mask), .stack_seg_load_i(ssl),
    .irq_enable_instr_i(ien), .irq_return_instr_i(irq_return_instr), .bus_cycle_done_i(done),
    .data_in_i(din), .addr_strobe_n_o(ads_n), .addr_o(addr), .upper_byte_sel_n_o(ube_n),
    .lower_byte_sel_n_o(lbe_n), .write_not_read_o(wnr), .data_not_code_o(dnc),
    .mem_not_io_o(mnio), .bus_lock_n_o(lock_n), .data_oe_o(doe),
    .bus_takeover_grant_o(grant), .cp_proceed_o(go), .exc_valid_o(exv),
    .exc_vector_o(exvec), .selftest_o(stest), .operand_xfer_o(oxfer), .operand_write_o(owr));
  ack_responder i_resp (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_strobe_n_i(ads_n),
    .bus_cycle_done_o(done), .data_o(din), .wait_i(wt), .vec_i(vec));
  // ==========
  // Helpers
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task chk(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic get_exc();
    r = 9'h000;
    for (int k = 0; k < 30; k++) begin
      if (exv === 1'b1) begin
        r = {1'b1, exvec};
        break;
      end
      cyc(1);
    end
    cyc(1);
  endtask
  task automatic wait_ads();
    for (int k = 0; k < 20 && ads_n !== 1'b0; k++)
      cyc(1);
    mirq = 1'b0;
  endtask
  task automatic nmi_edge();
    // Margin for synchroniser, hold count and edge latch
    nmi = 1'b0;
    cyc(12);
    nmi = 1'b1;
    cyc(12);
  endtask
  task automatic rst_run(input int n, input logic strap);
    rst_i = 1'b1;
    nrdy_n = strap;
    cyc(n);
    chk({ads_n, &addr, ube_n, lbe_n, wnr, dnc, mnio, lock_n, grant}, 9'h18A);
    rst_i = 1'b0;
    nrdy_n = 1'b1;
    treq = 1'b0;
    r = 9'h000;
    repeat (5) begin
      r[0] = r[0] | stest;
      cyc(1);
    end
  endtask
  function automatic logic [8:0] expect_irq(input logic m, input logic [7:0] v);
    return m ? {1'b1, v} : 9'h000;
  endfunction
  // Strobe, direction, memory data cycle, low byte only, transfer pulse
  function automatic logic [8:0] expect_oper(input logic w);
    return {1'h0, w, 1'h1, 1'h1, 1'h1, w, 1'h1, 1'h0, 1'h1};
  endfunction
  task chk_addr(input logic [22:0] g, input logic [22:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t addr %h want %h", $time, g, e);
    end
  endtask
  task results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    rst_run(20, 1'b1);
    chk(r, 9'h000);
    treq = 1'b1;
    cyc(4);
    rst_run(90, 1'b0);
    chk(r, 9'h001);
    rst_run(20, 1'b0);
    chk(r, 9'h000);
    cls = CP_STACK;
    nrdy_n = 1'b0;
    cyc(6);
    chk({8'h00, go}, 9'h000);
    nrdy_n = 1'b1;
    cyc(6);
    chk({8'h00, go}, 9'h001);
    cls = CP_NOWAIT;
    nrdy_n = 1'b0;
    cyc(3);
    chk({8'h00, go}, 9'h001);
    cls = CP_STACK;
    nrdy_n = 1'b1;
    exempt = 1'b1;
    flt_n = 1'b0;
    get_exc();
    chk(r, 9'h000);
    exempt = 1'b0;
    get_exc();
    cls = CP_NONE;
    flt_n = 1'b1;
    cyc(10);
    chk(r, 9'h110);
    for (i = 0; i < 6; i++) begin
      vec = 8'($random(seed));
      wt = 2'(i % 3 + 1);
      mask = (i != 0);
      mirq = 1'b1;
      cyc(10);
      pulse(bnd);
      wait_ads();
      get_exc();
      chk(r, expect_irq(mask, vec));
    end
    for (i = 0; i < 2; i++) begin
      mirq = 1'b1;
      cyc(10);
      if (i == 0)
        pulse(ssl);
      else
        pulse(ien);
      pulse(bnd);
      chk({7'h00, ads_n, lock_n}, 9'h003);
      cyc(3);
      chk({8'h00, lock_n}, 9'h001);
      pulse(bnd);
      wait_ads();
      get_exc();
      chk(r, expect_irq(1'b1, vec));
    end
    mask = 1'b0;
    nmi_edge();
    pulse(siter);
    get_exc();
    chk(r, 9'h102);
    nmi_edge();
    pulse(bnd);
    get_exc();
    chk(r, 9'h000);
    pulse(irq_return_instr);
    pulse(bnd);
    get_exc();
    chk(r, 9'h102);
    pulse(irq_return_instr);
    treq = 1'b1;
    nmi_edge();
    chk({8'h00, grant}, 9'h001);
    pulse(bnd);
    get_exc();
    chk(r, 9'h000);
    treq = 1'b0;
    cyc(2);
    pulse(bnd);
    get_exc();
    chk(r, 9'h102);
    pulse(irq_return_instr);
    for (i = 0; i < 2; i++) begin
      dir = i[0];
      caddr = 23'($random(seed));
      opreq = 1'b1;
      for (int k = 0; k < 20 && oxfer !== 1'b1; k++)
        cyc(1);
      opreq = 1'b0;
      chk({ads_n, wnr, dnc, mnio, lock_n, doe, ube_n, lbe_n, oxfer}, expect_oper(dir));
      chk_addr(addr, caddr);
      chk({8'h00, owr}, {8'h00, dir});
      cyc(20);
    end
    results();
  end
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
